/* File: hw/cbpc_pin_ctrl.sv */
// Breakpoint, clock output, code select and port A interrupt pins
// Assumes clk at 48 MHz x-domain free, pins asynchronous to clk
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "cbpc_map.svh"

// Operation
// RL1: Enabled address match drives breakpoint high
// RL2: Pulse mode: eight processor clocks high; select 2 holds 8 core clocks, which is four clocks of its 24 MHz output
// RL3: Latch mode: high until hit cleared
// RL4: Reset low clears every unit; the clock output enable, the port A synchronisers and the previous-pin stage reset to 1 instead
// RL5: Low code region from select pin
// RL6: Clock output 12/24/48 MHz from reference; select 2 toggles each clk and gives 24 MHz instead of 48
// RL7: Reset default 12 MHz, clock driven
// RL8: Control bit 1 tristates clock output
// RL9: Config bit0 picks port bit0 or irq0
// RL10: Irq0 edge when type 1, else level
// RL11: Config bit1 picks port bit1 or irq1
// RL12: Irq1 edge when type 1, else level
// RL13: Reset: breakpoint low, port pins floating
// RL14: Match always sets hit flag
module cbpc_pin_ctrl (
    input wire logic clk, // 48 MHz phase-locked core clock
    input wire logic rst_n, // Chip reset, active low
    input wire cbpc_pkg::cbpc_bus_t bus, // Register access
    output logic [7:0] rdata, // Read data, cycle after read
    input wire cbpc_pkg::cbpc_cpu_t cpu, // Processor fetch address
    input wire logic extCodeSelPin, // External code select pin
    output logic extFetch, // Fetch goes to external memory
    output logic matchHit, // Breakpoint output
    output logic cpuClkOut, // Clock output level
    output logic cpuClkOutOe, // Clock output enable
    input wire logic [1:0] portAIn, // Port A bits 1..0 pin level
    output logic [1:0] portAOut, // Port A bits 1..0 drive value
    output logic [1:0] portAOe, // Port A bits 1..0 enable
    output logic [1:0] extIrqReq, // Irq request to processor
    output logic irq // Block interrupt, level
);
    import cbpc_pkg::*;

    typedef struct packed {
        logic [15:0] matchAddr;
        logic en;
        logic pulse;
        logic hit;
        logic [1:0] clkSel;
        logic clkTri;
        logic [1:0] altCfg;
        logic [1:0] irqType;
        logic [1:0] pOut;
        logic [1:0] pOe;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prevPin;
        logic [1:0] irqReq;
        logic [1:0] stat;
        logic [1:0] mask;
        logic selSync1;
        logic selSync2;
        logic extF;
        logic [1:0] div;
        logic clkO;
        cbpc_bp_t bp;
        logic [5:0] bpCnt;
        logic bpOut;
        logic [7:0] rd;
        logic irqO;
        logic clkOe;
    } cbpc_state_t;

    cbpc_state_t s_r;
    cbpc_state_t s_nxt;
    logic match;
    logic [5:0] pulseLast;

    ////////////////////////////////////////////////////////////////////
    // Pulse counted in core clocks, exact whatever the divider phase
    always_comb begin
        case (s_r.clkSel)
            2'h0: pulseLast = {`CBPC_PULSE_CLKS, 2'h0} - 6'h01; // RL2
            2'h1: pulseLast = {1'b0, `CBPC_PULSE_CLKS, 1'b0} - 6'h01; // RL2
            default: pulseLast = {2'h0, `CBPC_PULSE_CLKS} - 6'h01; // RL2
        endcase
    end
    assign match = s_r.en && cpu.fetch && (cpu.addr == s_r.matchAddr); // RL1

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [1:0] fall;
        logic [7:0] rv;
        fall = 2'h0;
        rv = 8'h00;
        s_nxt = s_r;
        s_nxt.rd = 8'h00;
        // Clock divider: 12 MHz = /4, 24 MHz = /2; select 2 toggles each clk, also 24 MHz
        s_nxt.div = s_r.div + 2'h1;
        case (s_r.clkSel)
            2'h0: s_nxt.clkO = s_r.div[1]; // RL6
            2'h1: s_nxt.clkO = s_r.div[0]; // RL6
            default: s_nxt.clkO = ~s_r.clkO; // RL6
        endcase
        // Code fetch routing
        s_nxt.selSync1 = extCodeSelPin;
        s_nxt.selSync2 = s_r.selSync1;
        s_nxt.extF = cpu.fetch &&
            ((cpu.addr > `CBPC_INT_CODE_TOP) || s_r.selSync2); // RL5
        // Port A synchronisers and interrupt detection
        s_nxt.sync1 = portAIn;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prevPin = s_r.sync2;
        for (int i = 0; i < 2; i++) begin
            fall[i] = s_r.prevPin[i] && !s_r.sync2[i];
            if (!s_r.altCfg[i]) begin
                s_nxt.irqReq[i] = 1'b0; // RL9 RL11
            end else if (s_r.irqType[i]) begin
                s_nxt.irqReq[i] = fall[i]; // RL10 RL12
            end else begin
                s_nxt.irqReq[i] = !s_r.sync2[i]; // RL10 RL12
            end
            s_nxt.pOe[i] = s_r.pOe[i] && !s_r.altCfg[i];
        end
        // Breakpoint sequencing
        case (s_r.bp)
            CBPC_IDLE: begin
                if (match) begin
                    s_nxt.bp = s_r.pulse ? CBPC_PULSE : CBPC_LATCH;
                    s_nxt.bpCnt = 6'h00;
                end
            end
            CBPC_PULSE: begin
                s_nxt.bpCnt = s_r.bpCnt + 6'h01;
                if (s_r.bpCnt == pulseLast) begin
                    s_nxt.bp = CBPC_IDLE; // RL2
                end
            end
            CBPC_LATCH: begin
                if (!s_r.hit) begin
                    s_nxt.bp = CBPC_IDLE; // RL3
                end
            end
            default: s_nxt.bp = CBPC_IDLE;
        endcase
        s_nxt.bpOut = (s_nxt.bp != CBPC_IDLE);
        // Register reads
        if (bus.rd) begin
            case (bus.addr)
                `CBPC_OFS_MATCH_CTRL: rv = {5'h00, s_r.pulse, s_r.en, s_r.hit};
                `CBPC_OFS_MATCH_LO: rv = s_r.matchAddr[7:0];
                `CBPC_OFS_MATCH_HI: rv = s_r.matchAddr[15:8];
                `CBPC_OFS_CPU_CTRL: rv = {3'h0, s_r.clkSel, 1'b0, s_r.clkTri,
                    1'b0};
                `CBPC_OFS_PORTA_CFG: rv = {6'h00, s_r.altCfg};
                `CBPC_OFS_IRQ_TYPE: rv = {6'h00, s_r.irqType};
                `CBPC_OFS_IRQ_STAT: rv = {6'h00, s_r.stat};
                `CBPC_OFS_IRQ_MASK: rv = {6'h00, s_r.mask};
                `CBPC_OFS_PORTA_IO: rv = {2'h0, s_r.pOe, s_r.pOut, s_r.sync2};
                `CBPC_OFS_CODE_STAT: rv = {7'h00, s_r.selSync2};
                default: rv = 8'h00;
            endcase
            s_nxt.rd = rv;
            if (bus.addr == `CBPC_OFS_IRQ_STAT) begin
                s_nxt.stat = 2'h0;
            end
        end
        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                `CBPC_OFS_MATCH_CTRL: begin
                    s_nxt.en = bus.wdata[`CBPC_BIT_EN];
                    s_nxt.pulse = bus.wdata[`CBPC_BIT_PULSE];
                    if (bus.wdata[`CBPC_BIT_HIT]) begin
                        s_nxt.hit = 1'b0; // RL3
                    end
                end
                `CBPC_OFS_MATCH_LO: s_nxt.matchAddr[7:0] = bus.wdata;
                `CBPC_OFS_MATCH_HI: s_nxt.matchAddr[15:8] = bus.wdata;
                `CBPC_OFS_CPU_CTRL: begin
                    s_nxt.clkTri = bus.wdata[`CBPC_BIT_CLKTRI]; // RL8
                    s_nxt.clkSel = (bus.wdata[4:3] == 2'h3) ?
                        s_r.clkSel : bus.wdata[4:3];
                end
                `CBPC_OFS_PORTA_CFG: s_nxt.altCfg = bus.wdata[1:0];
                `CBPC_OFS_IRQ_TYPE: s_nxt.irqType = bus.wdata[1:0];
                `CBPC_OFS_IRQ_MASK: s_nxt.mask = bus.wdata[1:0];
                `CBPC_OFS_PORTA_IO: begin
                    s_nxt.pOut = bus.wdata[3:2];
                    s_nxt.pOe = bus.wdata[5:4] & ~s_r.altCfg; // RL9 RL11
                end
                default: ;
            endcase
        end
        // Hardware sets win over software clears
        if (match) begin
            s_nxt.hit = 1'b1; // RL14
        end
        s_nxt.stat = s_nxt.stat | s_nxt.irqReq;
        s_nxt.irqO = |(s_nxt.stat & s_nxt.mask);
        s_nxt.clkOe = !s_nxt.clkTri; // RL8
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0; // RL4 RL7 RL13
            s_r.clkSel <= `CBPC_CLKSEL_RST; // RL7
            s_r.clkOe <= 1'b1; // RL7
            s_r.sync1 <= 2'h3;
            s_r.sync2 <= 2'h3;
            s_r.prevPin <= 2'h3;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rd;
    assign extFetch = s_r.extF;
    assign matchHit = s_r.bpOut; // RL13
    assign cpuClkOut = s_r.clkO;
    assign cpuClkOutOe = s_r.clkOe; // RL7 RL8
    assign portAOut = s_r.pOut;
    assign portAOe = s_r.pOe; // RL13
    assign extIrqReq = s_r.irqReq;
    assign irq = s_r.irqO;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_pulseHeld;
        matchHit [*8];
    endsequence
    property p_matchOut;
        @(posedge clk) disable iff (!rst_n)
        (match && s_r.bp == CBPC_IDLE) |=> matchHit;
    endproperty
    a_matchOut: assert property (p_matchOut) else $error("no bp out"); // RL1
    property p_pulse48;
        @(posedge clk) disable iff (!rst_n)
        (match && s_r.bp == CBPC_IDLE && s_r.pulse && s_r.clkSel == 2'h2)
        |=> s_pulseHeld ##1 !matchHit;
    endproperty
    a_pulse48: assert property (p_pulse48) else $error("pulse len"); // RL2
    property p_latch;
        @(posedge clk) disable iff (!rst_n)
        (s_r.bp == CBPC_LATCH && s_r.hit) |=> matchHit;
    endproperty
    a_latch: assert property (p_latch) else $error("latch drop"); // RL3
    property p_hitSet;
        @(posedge clk) disable iff (!rst_n) match |=> s_r.hit;
    endproperty
    a_hitSet: assert property (p_hitSet) else $error("hit not set"); // RL14
    property p_codeRoute;
        @(posedge clk) disable iff (!rst_n)
        (cpu.fetch && cpu.addr <= `CBPC_INT_CODE_TOP) |=>
        (extFetch == $past(s_r.selSync2));
    endproperty
    a_codeRoute: assert property (p_codeRoute) else $error("code route"); // RL5
    property p_clkTri;
        @(posedge clk) disable iff (!rst_n)
        (bus.wr && bus.addr == `CBPC_OFS_CPU_CTRL) |=>
        (cpuClkOutOe == !$past(bus.wdata[`CBPC_BIT_CLKTRI]));
    endproperty
    a_clkTri: assert property (p_clkTri) else $error("clk oe"); // RL8
    property p_clk24;
        @(posedge clk) disable iff (!rst_n)
        (s_r.clkSel == 2'h1 && $stable(s_r.clkSel)) |=>
        (cpuClkOut == $past(s_r.div[0]));
    endproperty
    a_clk24: assert property (p_clk24) else $error("clk24"); // RL6
    property p_irq0Edge;
        @(posedge clk) disable iff (!rst_n)
        (s_r.altCfg[0] && s_r.irqType[0] && $fell(s_r.sync2[0]) &&
        $stable(s_r.altCfg[0]) && $stable(s_r.irqType[0])) |=> extIrqReq[0];
    endproperty
    a_irq0Edge: assert property (p_irq0Edge) else $error("irq0"); // RL10
    property p_irq1Lvl;
        @(posedge clk) disable iff (!rst_n)
        (s_r.altCfg[1] && !s_r.irqType[1] && !s_r.sync2[1]) |=> extIrqReq[1];
    endproperty
    a_irq1Lvl: assert property (p_irq1Lvl) else $error("irq1"); // RL12
    property p_altOe;
        @(posedge clk) disable iff (!rst_n)
        s_r.altCfg[0] |=> !portAOe[0];
    endproperty
    a_altOe: assert property (p_altOe) else $error("pa0 oe"); // RL9
    property p_altOe1;
        @(posedge clk) disable iff (!rst_n)
        s_r.altCfg[1] |=> !portAOe[1];
    endproperty
    a_altOe1: assert property (p_altOe1) else $error("pa1 oe"); // RL11
endmodule : cbpc_pin_ctrl

/* File: inc/cbpc_map.svh */
// Register map, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design and bench files
`ifndef CBPC_MAP_SVH
`define CBPC_MAP_SVH
`define CBPC_OFS_MATCH_CTRL 4'h0
`define CBPC_OFS_MATCH_LO 4'h1
`define CBPC_OFS_MATCH_HI 4'h2
`define CBPC_OFS_CPU_CTRL 4'h3
`define CBPC_OFS_PORTA_CFG 4'h4
`define CBPC_OFS_IRQ_TYPE 4'h5
`define CBPC_OFS_IRQ_STAT 4'h6
`define CBPC_OFS_IRQ_MASK 4'h7
`define CBPC_OFS_PORTA_IO 4'h8
`define CBPC_OFS_CODE_STAT 4'h9
`define CBPC_BIT_HIT 0
`define CBPC_BIT_EN 1
`define CBPC_BIT_PULSE 2
`define CBPC_BIT_CLKSEL 3
`define CBPC_BIT_CLKTRI 1
`define CBPC_CLKSEL_RST 2'h0
`define CBPC_PULSE_CLKS 4'h8
`define CBPC_INT_CODE_TOP 16'h3FFF
`endif

/* File: inc/cbpc_pkg.sv */
// Types shared by the pin control block
// Assumes cbpc_map.svh is on the include path
package cbpc_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cbpc_bus_t;
    typedef enum logic [1:0] {
        CBPC_CLK12,
        CBPC_CLK24,
        CBPC_CLK48,
        CBPC_CLKRSV
    } cbpc_clksel_t;
    typedef enum logic [1:0] {
        CBPC_IDLE,
        CBPC_PULSE,
        CBPC_LATCH
    } cbpc_bp_t;
    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
    } cbpc_cpu_t;
endpackage : cbpc_pkg

/* File: sim/cbpc_pin_model.sv */
// Port A pins with interrupt sources on them
// Assumes pull-ups on both pins, sources pull low only
`timescale 1ns/1ns
module cbpc_pin_model (
    input wire logic [1:0] oe, // Design drive enable
    input wire logic [1:0] out, // Design drive value
    input wire logic [1:0] pullLow, // Source asserts interrupt
    output logic [1:0] pin // Resolved pin level
);
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin[i] = oe[i] ? out[i] : ~pullLow[i];
        end
    end
endmodule : cbpc_pin_model

/* File: sim/tb.sv */
// Self-checking bench for the pin control block
// Assumes cbpc_pkg and cbpc_pin_model are compiled first
`timescale 1ns/1ns
`include "cbpc_map.svh"
module tb;
    import cbpc_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic selPin = 0;
    cbpc_bus_t bus = '0;
    cbpc_cpu_t cpu = '0;
    logic [1:0] pullLow = 2'h0;
    logic [1:0] pin;
    logic [7:0] rdata;
    logic extFetch, matchHit, cpuClkOut, cpuClkOutOe, irq;
    logic [1:0] portAOut, portAOe, extIrqReq;
    int errTotal = 0;
    int numChecks = 0;
    int seed = 32'h88E9C52C;
    cbpc_pin_ctrl uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .cpu(cpu), .extCodeSelPin(selPin), .extFetch(extFetch),
        .matchHit(matchHit), .cpuClkOut(cpuClkOut),
        .cpuClkOutOe(cpuClkOutOe), .portAIn(pin), .portAOut(portAOut),
        .portAOe(portAOe), .extIrqReq(extIrqReq), .irq(irq));
    cbpc_pin_model pins (.oe(portAOe), .out(portAOut), .pullLow(pullLow),
        .pin(pin));
    initial forever #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic testDone;
        if (errTotal == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : testDone
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    task automatic rd(logic [3:0] a, logic [7:0] e, string n);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(n, e, rdata);
    endtask : rd
    task automatic rstChk;
        chk("resetPins", 16'h0010,
            {matchHit, portAOe, cpuClkOutOe, irq, extIrqReq, cpuClkOut});
    endtask : rstChk
    function automatic logic expFetch(logic [15:0] a, logic s);
        return (a > `CBPC_INT_CODE_TOP) || s;
    endfunction : expFetch
    function automatic int pulseLen(logic [1:0] sel);
        return int'(`CBPC_PULSE_CLKS) << (2 - sel);
    endfunction : pulseLen
    ////////////////////////////////////////////////////////////////////////
    task automatic clkChk(logic [1:0] sel);
        int n;
        logic p;
        n = 0;
        wr(`CBPC_OFS_CPU_CTRL, {3'h0, sel, 3'h0});
        tick(8);
        p = cpuClkOut;
        repeat (48) begin
            tick(1);
            if (cpuClkOut === 1'b1 && p === 1'b0) n++;
            p = cpuClkOut;
        end
        chk("clkRises", (sel == 2'h0) ? 12 : 24, n);
        chk("clkOe", 1, cpuClkOutOe);
    endtask : clkChk
    task automatic bp(logic pulse, logic [1:0] sel);
        logic [15:0] a;
        int n;
        a = 16'($random(seed));
        wr(`CBPC_OFS_CPU_CTRL, {3'h0, sel, 3'h0});
        wr(`CBPC_OFS_MATCH_LO, a[7:0]);
        wr(`CBPC_OFS_MATCH_HI, a[15:8]);
        wr(`CBPC_OFS_MATCH_CTRL, {5'h0, pulse, 2'h2});
        @(posedge clk);
        cpu <= '{a ^ 16'h0100, 1'b1};
        tick(4);
        chk("missHit", 0, matchHit);
        cpu <= '{a, 1'b1};
        @(posedge clk);
        cpu.fetch <= 1'b0;
        #1;
        for (n = 0; n < 10 && matchHit !== 1'b1; n++) tick(1);
        for (n = 0; n < 100 && matchHit === 1'b1; n++) tick(1);
        chk("hitWidth", pulse ? pulseLen(sel) : 100, n);
        rd(`CBPC_OFS_MATCH_CTRL, {5'h0, pulse, 2'h3}, "hitFlag");
    endtask : bp
    task automatic irqChk(int b, logic edgeMode);
        logic [1:0] m;
        int n;
        m = 2'h1 << b;
        wr(`CBPC_OFS_PORTA_IO, 8'h3C);
        wr(`CBPC_OFS_PORTA_CFG, m);
        wr(`CBPC_OFS_IRQ_TYPE, edgeMode ? m : 2'h0);
        wr(`CBPC_OFS_IRQ_MASK, m);
        rd(`CBPC_OFS_IRQ_STAT, 8'h00, "statIdle");
        chk("altOe", {14'h0000, ~m}, portAOe);
        pullLow <= m;
        n = 0;
        repeat (10) begin
            tick(1);
            if (extIrqReq === m) n++;
        end
        if (edgeMode) chk("edgeReq", 1, n);
        else chk("levelReq", m, extIrqReq);
        chk("irqUp", 1, irq);
        pullLow <= 2'h0;
        tick(6);
        chk("reqIdle", 0, extIrqReq);
        rd(`CBPC_OFS_IRQ_STAT, {6'h0, m}, "statSet");
        tick(2);
        chk("irqDown", 0, irq);
        wr(`CBPC_OFS_PORTA_CFG, 8'h00);
    endtask : irqChk
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(3);
        rstChk();
        rst_n <= 1'b1;
        rd(`CBPC_OFS_CPU_CTRL, 8'h00, "clkSelReset");
        rd(4'hF, 8'h00, "unmapped");
        wr(`CBPC_OFS_PORTA_IO, 8'h3C);
        rd(`CBPC_OFS_PORTA_IO, 8'h3F, "ioDriven");
        wr(`CBPC_OFS_PORTA_IO, 8'h14);
        rd(`CBPC_OFS_PORTA_IO, 8'h17, "ioFloat");
        chk("portOut", 16'h0001, portAOut);
        for (int s = 0; s < 3; s++) clkChk(s);
        wr(`CBPC_OFS_CPU_CTRL, 8'h02);
        tick(2);
        chk("clkTri", 0, cpuClkOutOe);
        for (int s = 0; s < 3; s++) bp(1'b1, s);
        bp(1'b0, 2'h2);
        wr(`CBPC_OFS_MATCH_CTRL, 8'h03);
        tick(3);
        chk("hitClear", 0, matchHit);
        bp(1'b0, 2'h1);
        rst_n <= 1'b0;
        tick(1);
        rstChk();
        rst_n <= 1'b1;
        rd(`CBPC_OFS_MATCH_CTRL, 8'h00, "ctrlReset");
        for (int i = 0; i < 16; i++) begin
            selPin <= $random(seed);
            cpu <= '{(i == 0) ? 16'h3FFF : (i == 1) ? 16'h4000 :
                16'($random(seed)), 1'b1};
            tick(5);
            chk("extFetch", expFetch(cpu.addr, selPin), extFetch);
            rd(`CBPC_OFS_CODE_STAT, {7'h00, selPin}, "codeSel");
        end
        for (int b = 0; b < 2; b++) begin
            irqChk(b, 1'b1);
            irqChk(b, 1'b0);
        end
        testDone();
    end
endmodule : tb
